//--- logic/monitor_pkg.sv
// Function
// R1: Digital monitor source codes 00,01,03,04,05,06,07 select the monitored quantity.
// R2: Pulse-width mode runs at a constant period whatever the monitored value.
// R3: High time is proportional to quantity over its full scale per source.
// R4: An 8-bit gain scales every pulse-width source, never the frequency-modulated one.
// R5: A full-scale pulse-width output stays continuously high for meter calibration.
// R6: Code 03 makes output frequency follow inverter output frequency, no gain.
// R7: Frequency-modulated output tops out at the maximum frequency setting.
// R8: Voltage and current outputs have own selectors with codes 00,01,04..07.
// R9: Voltage output spans 0 to 10 V, current output 4 to 20 mA.
// R10: Voltage output has own gain (default 180) and offset 0.0 to 10.0 V.
// R11: Current output has own gain (default 80) and offset 0.0 to 20.0 mA.
// R12: Duty saturates at always high and converter codes clamp at full scale.
package monitor_pkg;

  // Clock and pulse-width period
  localparam int CLK_PERIOD_NS = 100;
  localparam int PWM_PERIOD_NS = 6400000;
  localparam int PWM_PERIOD_CYCLES = PWM_PERIOD_NS / CLK_PERIOD_NS;

  // Source codes
  localparam logic [2:0] SRC_FREQ_PWM = 3'h0;
  localparam logic [2:0] SRC_CURRENT = 3'h1;
  localparam logic [2:0] SRC_UNUSED = 3'h2;
  localparam logic [2:0] SRC_FREQ_FM = 3'h3;
  localparam logic [2:0] SRC_VOLTAGE = 3'h4;
  localparam logic [2:0] SRC_POWER = 3'h5;
  localparam logic [2:0] SRC_THERMAL = 3'h6;
  localparam logic [2:0] SRC_RAMPED = 3'h7;

  // Full scales in 0.1 % units: 200 % and 100 %
  localparam logic [15:0] FS_DOUBLE_PCT = 16'h07d0;
  localparam logic [15:0] FS_SINGLE_PCT = 16'h03e8;

  // Normalised fraction: 1024 means full scale
  localparam int FRAC_BITS = 10;
  localparam logic [10:0] FRAC_FULL = 11'h400;
  localparam int GAIN_SHIFT = 7;
  localparam int DIV_STEPS = 26;

  // Gain and offset reset values
  localparam logic [7:0] DIG_GAIN_RESET = 8'h80;
  localparam logic [7:0] VOLT_GAIN_RESET = 8'hb4;
  localparam logic [7:0] CURR_GAIN_RESET = 8'h50;
  localparam logic [7:0] OFFSET_RESET = 8'h00;

  // Offsets in 0.1 V / 0.1 mA, converter codes in 10 mV / 10 uA
  localparam logic [7:0] VOLT_OFFSET_MAX = 8'h64;
  localparam logic [7:0] CURR_OFFSET_MAX = 8'hc8;
  localparam logic [3:0] OFFSET_TO_CODE = 4'ha;
  localparam logic [10:0] VOLT_ZERO = 11'h000;
  localparam logic [10:0] VOLT_SPAN = 11'h3e8;
  localparam logic [10:0] VOLT_FULL = 11'h3e8;
  localparam logic [10:0] CURR_ZERO = 11'h190;
  localparam logic [10:0] CURR_SPAN = 11'h640;
  localparam logic [10:0] CURR_FULL = 11'h7d0;

  // Frequency-modulated output: one toggle per modulus of 0.01 Hz steps
  localparam int FM_TOGGLE_MODULUS = (1000000000 / CLK_PERIOD_NS) * 50;

  typedef struct packed {
    logic [15:0] output_frequency;
    logic [15:0] output_current;
    logic [15:0] output_voltage;
    logic [15:0] input_power;
    logic [15:0] thermal_ratio;
    logic [15:0] ramped_frequency;
  } monitor_quantities_s;

endpackage

//--- logic/frac_divider.sv
`timescale 1ns/1ns
// Serial divider: quotient = numerator * 1024 / denominator, numerator <= denominator
module frac_divider
  import monitor_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [15:0] numerator,
  input wire logic [15:0] denominator,
  output logic done,
  output logic [10:0] quotient
);

  logic busy_reg;
  logic [4:0] step_reg;
  logic [15:0] rem_reg;
  logic [15:0] den_reg;
  logic [25:0] dividend_reg;
  logic [10:0] quo_reg;
  logic done_reg;
  logic [16:0] rem_shift;
  logic fits;
  logic last_step;

  // One restoring step per clock
  assign rem_shift = {rem_reg, dividend_reg[25]};
  assign fits = rem_shift >= {1'b0, den_reg};
  assign last_step = step_reg == 5'(DIV_STEPS - 1);

  // Zero denominator gives zero rather than all ones
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      busy_reg <= 1'b0;
      step_reg <= 5'h00;
      rem_reg <= 16'h0000;
      den_reg <= 16'h0000;
      dividend_reg <= 26'h0000000;
      quo_reg <= 11'h000;
      done_reg <= 1'b0;
    end
    else if (start && !busy_reg)
    begin
      busy_reg <= 1'b1;
      step_reg <= 5'h00;
      rem_reg <= 16'h0000;
      den_reg <= denominator;
      dividend_reg <= {numerator, 10'h000};
      quo_reg <= 11'h000;
      done_reg <= 1'b0;
    end
    else if (busy_reg)
    begin
      step_reg <= step_reg + 5'h01;
      rem_reg <= fits ? 16'(rem_shift - {1'b0, den_reg}) : rem_shift[15:0];
      dividend_reg <= {dividend_reg[24:0], 1'b0};
      quo_reg <= {quo_reg[9:0], fits && (den_reg != 16'h0000)};
      busy_reg <= !last_step;
      done_reg <= last_step;
    end
    else
    begin
      done_reg <= 1'b0;
    end
  end

  assign done = done_reg;
  assign quotient = quo_reg;

  // Done is quiet the cycle after start and lands exactly 27 cycles after it
  AST_DIV_LATENCY: assert property (@(posedge ref_clk) disable iff (srst) // [R3]
    (start && !busy_reg) |=> !done ##26 done)
    else $error("divider result not ready 27 cycles after start");

endmodule

//--- logic/monitor_output_generator.sv
`timescale 1ns/1ns
module monitor_output_generator
  import monitor_pkg::*;
#(
  parameter int PWM_PERIOD = PWM_PERIOD_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire monitor_quantities_s quantities,
  input wire logic [15:0] max_frequency_setting,
  input wire logic [2:0] digital_monitor_source_sel,
  input wire logic [2:0] voltage_monitor_source_sel,
  input wire logic [2:0] current_monitor_source_sel,
  input wire logic [7:0] pulse_width_gain,
  input wire logic [7:0] voltage_monitor_gain,
  input wire logic [7:0] voltage_monitor_offset,
  input wire logic [7:0] current_monitor_gain,
  input wire logic [7:0] current_monitor_offset,
  input wire logic pwm_full_scale_test,
  output logic digital_monitor_out,
  output logic [10:0] voltage_monitor_out,
  output logic [10:0] current_monitor_out
);

  // Picks {numerator, full scale}; numerator is clamped to full scale
  function automatic logic [31:0] pick_source(input logic [2:0] code,
    input monitor_quantities_s q, input logic [15:0] fmax);
    logic [15:0] value;
    logic [15:0] full;
    value = 16'h0000;
    full = fmax;
    case (code)
      SRC_FREQ_PWM, SRC_FREQ_FM: value = q.output_frequency;
      SRC_CURRENT:
      begin
        value = q.output_current;
        full = FS_DOUBLE_PCT;
      end
      SRC_VOLTAGE:
      begin
        value = q.output_voltage;
        full = FS_SINGLE_PCT;
      end
      SRC_POWER:
      begin
        value = q.input_power;
        full = FS_DOUBLE_PCT;
      end
      SRC_THERMAL:
      begin
        value = q.thermal_ratio;
        full = FS_SINGLE_PCT;
      end
      SRC_RAMPED: value = q.ramped_frequency;
      default: value = 16'h0000;
    endcase
    if (value > full)
      value = full;
    return {value, full};
  endfunction

  // Gain of 128 is unity; anything past full scale saturates
  function automatic logic [10:0] apply_gain(input logic [10:0] frac, input logic [7:0] gain);
    logic [18:0] prod;
    prod = frac * gain;
    return (prod[18:GAIN_SHIFT] > {1'b0, FRAC_FULL}) ? FRAC_FULL : prod[17:GAIN_SHIFT];
  endfunction

  // Converter code: zero + span share + offset, clamped at full
  function automatic logic [10:0] analog_level(input logic [10:0] unit, input logic [7:0] offset,
    input logic [10:0] zero, input logic [10:0] span, input logic [10:0] full);
    logic [21:0] spanned;
    logic [11:0] off_code;
    logic [12:0] sum;
    spanned = unit * span;
    off_code = offset * OFFSET_TO_CODE;
    sum = {2'b00, zero} + {2'b00, spanned[20:FRAC_BITS]} + {1'b0, off_code};
    return (sum > {2'b00, full}) ? full : sum[10:0];
  endfunction

  logic [16:0] period_cnt_reg;
  logic [16:0] high_reg;
  logic [16:0] pending_high_reg;
  logic [7:0] dig_gain_reg;
  logic [7:0] volt_gain_reg;
  logic [7:0] volt_offset_reg;
  logic [7:0] curr_gain_reg;
  logic [7:0] curr_offset_reg;
  logic test_reg;
  logic [29:0] fm_acc_reg;
  logic fm_level_reg;
  logic digital_out_reg;
  logic [10:0] volt_out_reg;
  logic [10:0] curr_out_reg;

  // Period timing and source selection
  wire period_start = period_cnt_reg == 17'h00000;
  wire period_end = period_cnt_reg == 17'(PWM_PERIOD - 1);
  wire fm_mode = digital_monitor_source_sel == SRC_FREQ_FM; // [R1]
  wire [2:0] volt_code = (voltage_monitor_source_sel == SRC_FREQ_FM) ? SRC_UNUSED
    : voltage_monitor_source_sel; // [R8]
  wire [2:0] curr_code = (current_monitor_source_sel == SRC_FREQ_FM) ? SRC_UNUSED
    : current_monitor_source_sel; // [R8]
  wire [31:0] dig_pick = pick_source(digital_monitor_source_sel, quantities,
    max_frequency_setting); // [R1] [R3]
  wire [31:0] volt_pick = pick_source(volt_code, quantities, max_frequency_setting);
  wire [31:0] curr_pick = pick_source(curr_code, quantities, max_frequency_setting);

  wire dig_done;
  wire volt_done;
  wire curr_done;
  wire [10:0] dig_frac;
  wire [10:0] volt_frac;
  wire [10:0] curr_frac;

  frac_divider dig_div (.ref_clk(ref_clk), .srst(srst), .start(period_start),
    .numerator(dig_pick[31:16]), .denominator(dig_pick[15:0]), .done(dig_done),
    .quotient(dig_frac));
  frac_divider volt_div (.ref_clk(ref_clk), .srst(srst), .start(period_start),
    .numerator(volt_pick[31:16]), .denominator(volt_pick[15:0]), .done(volt_done),
    .quotient(volt_frac));
  frac_divider curr_div (.ref_clk(ref_clk), .srst(srst), .start(period_start),
    .numerator(curr_pick[31:16]), .denominator(curr_pick[15:0]), .done(curr_done),
    .quotient(curr_frac));

  // Duty and high time; test forces full scale
  wire [10:0] duty = test_reg ? FRAC_FULL : apply_gain(dig_frac, dig_gain_reg); // [R4] [R5] [R12]
  wire [27:0] high_prod = duty * 17'(PWM_PERIOD);
  wire [16:0] high_count = high_prod[26:FRAC_BITS]; // [R3]
  wire pwm_level = period_cnt_reg < high_reg; // [R3] [R5]
  wire [10:0] volt_code_out = analog_level(apply_gain(volt_frac, volt_gain_reg),
    volt_offset_reg, VOLT_ZERO, VOLT_SPAN, VOLT_FULL); // [R9] [R10] [R12]
  wire [10:0] curr_code_out = analog_level(apply_gain(curr_frac, curr_gain_reg),
    curr_offset_reg, CURR_ZERO, CURR_SPAN, CURR_FULL); // [R9] [R11] [R12]

  // Frequency-modulated path ignores gain entirely
  wire [15:0] fm_inc = (quantities.output_frequency > max_frequency_setting)
    ? max_frequency_setting : quantities.output_frequency; // [R6] [R7]
  wire [30:0] fm_sum = {1'b0, fm_acc_reg} + {15'h0000, fm_inc};
  wire fm_wrap = fm_sum >= 31'(FM_TOGGLE_MODULUS);

  // Fixed period counter, independent of the monitored value
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      period_cnt_reg <= 17'h00000;
    else
      period_cnt_reg <= period_end ? 17'h00000 : period_cnt_reg + 17'h00001; // [R2]
  end

  // Settings are latched once per period so a period never sees a half update
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      dig_gain_reg <= DIG_GAIN_RESET;
      volt_gain_reg <= VOLT_GAIN_RESET; // [R10]
      volt_offset_reg <= OFFSET_RESET;
      curr_gain_reg <= CURR_GAIN_RESET; // [R11]
      curr_offset_reg <= OFFSET_RESET;
      test_reg <= 1'b0;
    end
    else if (period_start)
    begin
      dig_gain_reg <= pulse_width_gain;
      volt_gain_reg <= voltage_monitor_gain;
      volt_offset_reg <= (voltage_monitor_offset > VOLT_OFFSET_MAX) ? VOLT_OFFSET_MAX
        : voltage_monitor_offset; // [R10]
      curr_gain_reg <= current_monitor_gain;
      curr_offset_reg <= (current_monitor_offset > CURR_OFFSET_MAX) ? CURR_OFFSET_MAX
        : current_monitor_offset; // [R11]
      test_reg <= pwm_full_scale_test;
    end
  end

  // New high time waits for the period boundary to keep each period whole
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pending_high_reg <= 17'h00000;
      high_reg <= 17'h00000;
    end
    else
    begin
      if (dig_done)
        pending_high_reg <= high_count;
      if (period_end)
        high_reg <= pending_high_reg; // [R2]
    end
  end

  // Modulo accumulator gives an exact average rate in 0.01 Hz steps
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      fm_acc_reg <= 30'h00000000;
      fm_level_reg <= 1'b0;
    end
    else if (fm_wrap)
    begin
      fm_acc_reg <= 30'(fm_sum - 31'(FM_TOGGLE_MODULUS));
      fm_level_reg <= !fm_level_reg; // [R6]
    end
    else
    begin
      fm_acc_reg <= fm_sum[29:0];
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      digital_out_reg <= 1'b0;
      volt_out_reg <= VOLT_ZERO;
      curr_out_reg <= CURR_ZERO;
    end
    else
    begin
      digital_out_reg <= fm_mode ? fm_level_reg : pwm_level; // [R1]
      if (volt_done)
        volt_out_reg <= volt_code_out; // [R9]
      if (curr_done)
        curr_out_reg <= curr_code_out; // [R9]
    end
  end

  assign digital_monitor_out = digital_out_reg;
  assign voltage_monitor_out = volt_out_reg;
  assign current_monitor_out = curr_out_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  AST_SEL_FM: assert property ((fm_mode && $stable(fm_mode)) |=> // [R1]
    digital_monitor_out == $past(fm_level_reg))
    else $error("frequency-modulated code does not drive the output");
  AST_PERIOD_WRAP: assert property (period_end |=> period_start ##1 !period_start) // [R2]
    else $error("pulse-width period does not restart");
  AST_PWM_HIGH: assert property ((!fm_mode && pwm_level) |=> digital_monitor_out) // [R3]
    else $error("output low inside the high time");
  AST_GAIN_ZERO: assert property ((dig_done && dig_gain_reg == 8'h00 && !test_reg) // [R4]
    |=> pending_high_reg == 17'h00000)
    else $error("zero gain did not give zero high time");
  // Test level is latched with the period, so its high time is whole at the boundary
  AST_FULL_HIGH: assert property ((period_end && test_reg) |=> high_reg == 17'(PWM_PERIOD)) // [R5]
    else $error("full-scale test is not continuously high");
  AST_FM_TOGGLE: assert property (fm_wrap |=> $changed(fm_level_reg)) // [R6]
    else $error("frequency-modulated output failed to toggle");
  // Above the maximum, the accumulator must grow by the maximum and no more
  AST_FM_CLAMP: assert property ((!fm_wrap // [R7]
    && quantities.output_frequency >= max_frequency_setting)
    |=> fm_acc_reg == $past(fm_acc_reg) + 30'($past(max_frequency_setting)))
    else $error("frequency step not held at the maximum setting");
  AST_ANA_CODE: assert property ((current_monitor_source_sel == SRC_FREQ_FM) // [R8]
    |-> curr_pick[31:16] == 16'h0000)
    else $error("analog output accepted an unsupported code");
  AST_VOLT_RANGE: assert property (voltage_monitor_out <= VOLT_FULL) // [R9] [R10] [R12]
    else $error("voltage code above full scale");
  AST_CURR_RANGE: assert property (current_monitor_out >= CURR_ZERO // [R9] [R11] [R12]
    && current_monitor_out <= CURR_FULL)
    else $error("current code outside 4 to 20 mA");
  AST_VOLT_LOAD: assert property (volt_done |=> voltage_monitor_out == $past(volt_code_out)) // [R10]
    else $error("voltage code not loaded at divider completion");

  COV_FM_RUN: cover property (fm_mode && fm_wrap);
  COV_FULL_HIGH: cover property (!fm_mode && high_reg == 17'(PWM_PERIOD));
  COV_VOLT_FULL: cover property (voltage_monitor_out == VOLT_FULL);
  COV_CURR_FULL: cover property (current_monitor_out == CURR_FULL);

endmodule

//--- verification/panel_meter.sv
`timescale 1ns/1ns
// Moving-coil meter stand-in: measures the digital monitor line cycle by cycle
module panel_meter
(
  input wire logic ref_clk,
  input wire logic meter_in,
  output logic [31:0] last_period,
  output logic [31:0] last_high,
  output logic [31:0] high_run
);
  logic prev_reg;
  logic [31:0] per_cnt;
  logic [31:0] high_cnt;

  // A meter has no reset; start from known counts
  initial
  begin
    prev_reg = 1'b0;
    per_cnt = 32'h0;
    high_cnt = 32'h0;
    last_period = 32'h0;
    last_high = 32'h0;
    high_run = 32'h0;
  end

  // Each rising edge closes one measured period
  always @(posedge ref_clk)
  begin
    prev_reg <= meter_in;
    high_run <= meter_in ? high_run + 32'h1 : 32'h0; // Only way to see a steady high
    if (meter_in && !prev_reg)
    begin
      last_period <= per_cnt;
      last_high <= high_cnt;
      per_cnt <= 32'h1;
      high_cnt <= 32'h1;
    end
    else
    begin
      per_cnt <= per_cnt + 32'h1;
      high_cnt <= high_cnt + {31'h0, meter_in};
    end
  end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import monitor_pkg::*;
;
  // Short period keeps the run small; all pulse-width figures below follow from it
  localparam int PER = 200;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  monitor_quantities_s qty;
  logic [15:0] fmax;
  logic [2:0] dsel;
  logic [2:0] vsel;
  logic [2:0] csel;
  logic [7:0] pgain;
  logic [7:0] vgain;
  logic [7:0] voff;
  logic [7:0] cgain;
  logic [7:0] coff;
  logic ftest;
  logic dout;
  logic [10:0] vout;
  logic [10:0] cout;
  logic [31:0] m_per;
  logic [31:0] m_high;
  logic [31:0] m_run;
  int errors = 0;
  int n_compared = 0;
  int case_no = 0;

  always #50 ref_clk = ~ref_clk;

  monitor_output_generator #(.PWM_PERIOD(PER)) monitor_output_generator_inst (
    .ref_clk(ref_clk),
    .srst(srst),
    .quantities(qty),
    .max_frequency_setting(fmax),
    .digital_monitor_source_sel(dsel),
    .voltage_monitor_source_sel(vsel),
    .current_monitor_source_sel(csel),
    .pulse_width_gain(pgain),
    .voltage_monitor_gain(vgain),
    .voltage_monitor_offset(voff),
    .current_monitor_gain(cgain),
    .current_monitor_offset(coff),
    .pwm_full_scale_test(ftest),
    .digital_monitor_out(dout),
    .voltage_monitor_out(vout),
    .current_monitor_out(cout)
  );

  panel_meter panel_meter_inst (
    .ref_clk(ref_clk),
    .meter_in(dout),
    .last_period(m_per),
    .last_high(m_high),
    .high_run(m_run)
  );

  // Shared compare, four-state safe
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Settings land mid-period; four periods let the new high time show twice
  task automatic run_case(input logic [2:0] d, input logic [7:0] pg, input logic [2:0] v,
    input logic [7:0] vg, input logic [7:0] vo, input logic [2:0] c, input logic [7:0] cg,
    input logic [7:0] co, input logic [7:0] eh, input logic [10:0] ev, input logic [10:0] ec);
    @(posedge ref_clk);
    dsel <= d;
    pgain <= pg;
    vsel <= v;
    vgain <= vg;
    voff <= vo;
    csel <= c;
    cgain <= cg;
    coff <= co;
    repeat (4 * PER + 5) @(posedge ref_clk);
    #1;
    case_no++;
    if (eh == 8'hc8)
      check("steady high", 32'h1, {31'h0, m_run >= 2 * PER});
    else
    begin
      check("pwm period", PER, m_per);
      check("pwm high time", {24'h0, eh}, m_high);
    end
    check("voltage code", {21'h0, ev}, {21'h0, vout});
    check("current code", {21'h0, ec}, {21'h0, cout});
    $display("test case %0d done", case_no);
  endtask

  initial
  begin
    qty.output_frequency = 16'h0bb8;
    qty.output_current = 16'h01f4;
    qty.output_voltage = 16'h02ee;
    qty.input_power = 16'h03e8;
    qty.thermal_ratio = 16'h00fa;
    qty.ramped_frequency = 16'h05dc;
    fmax = 16'h1770;
    dsel = 3'h0;
    vsel = 3'h0;
    csel = 3'h0;
    pgain = 8'h80;
    vgain = 8'hb4;
    voff = 8'h00;
    cgain = 8'h50;
    coff = 8'h00;
    ftest = 1'b0;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    check("reset digital", 32'h0, {31'h0, dout});
    check("reset voltage", 32'h0, {21'h0, vout});
    check("reset current", 32'h190, {21'h0, cout});
    $display("test reset done");
    // Every pulse-width code on the digital output, five codes each on voltage (no 00) and current (no 04), each with its own full scale
    run_case(3'h0, 8'h80, 3'h1, 8'h80, 8'h00,
      3'h6, 8'h80, 8'h00, 8'h64, 11'h0fa, 11'h320);
    run_case(3'h1, 8'h80, 3'h1, 8'hb4, 8'h14,
      3'h6, 8'h50, 8'h32, 8'h32, 11'h227, 11'h47e);
    run_case(3'h4, 8'h80, 3'h4, 8'h80, 8'h00,
      3'h0, 8'h80, 8'h00, 8'h96, 11'h2ee, 11'h4b0);
    run_case(3'h5, 8'h80, 3'h5, 8'h80, 8'h00,
      3'h5, 8'h80, 8'h00, 8'h64, 11'h1f4, 11'h4b0);
    run_case(3'h6, 8'h80, 3'h6, 8'h80, 8'h00,
      3'h7, 8'h80, 8'h00, 8'h32, 11'h0fa, 11'h320);
    run_case(3'h7, 8'h80, 3'h7, 8'h80, 8'h00,
      3'h1, 8'h80, 8'h00, 8'h32, 11'h0fa, 11'h320);
    // Gain below unity, gain and offset past full scale
    run_case(3'h4, 8'h40, 3'h4, 8'hff, 8'hff,
      3'h4, 8'hff, 8'hff, 8'h4b, 11'h3e8, 11'h7d0);
    run_case(3'h4, 8'hff, 3'h2, 8'h80, 8'h00,
      3'h3, 8'h80, 8'h00, 8'hc8, 11'h000, 11'h190);
    run_case(3'h0, 8'hff, 3'h1, 8'h80, 8'h00,
      3'h6, 8'h80, 8'h00, 8'hc7, 11'h0fa, 11'h320);
    // Calibration drive with zero gain on the analog side, offset only
    @(posedge ref_clk);
    ftest <= 1'b1;
    run_case(3'h1, 8'h80, 3'h0, 8'h00, 8'h0a,
      3'h0, 8'h00, 8'h0a, 8'hc8, 11'h064, 11'h1f4);
    @(posedge ref_clk);
    ftest <= 1'b0;
    // Frequency mode: input above the maximum, gain zero must not matter
    fmax <= 16'hc350;
    qty.output_frequency <= 16'hea60;
    dsel <= 3'h3;
    pgain <= 8'h00;
    repeat (16'ha410) @(posedge ref_clk);
    #1;
    check("fm period", 32'h4e20, m_per);
    check("fm high time", 32'h2710, m_high);
    $display("test frequency mode done");
    complete_run();
  end
endmodule
